/* File: rtl/loop_mode_ctrl.sv */
// Single-instruction loop-mode control for the fetch and decode path.
//
// Functional notes
// - Decode register plus two-word queue hold loop.
// - No instruction fetches while loop runs.
// - Enter only on loop-back, displacement minus four.
// - Entry automatic, invisible, no software control.
// - Double fetch; commit on second looped fetch.
// - Branch decrements counter word, tests minus one.
// - In loop, interrupts taken only after counted branch.
// - Interrupt ends loop; later re-entry allowed.
// - Tracing traps both instructions, blocks loop.
// - Reset aborts and clears loop state.
// - Bus error resumes without refetching loop.
// - Only one-word indirect-mode encodings qualify.
// - Listed data move operand pairs qualify.
// - Memory-to-register arithmetic and address forms.
// - Register-to-memory arithmetic and exclusive-or qualify.
// - Extend forms predecrement; compare postincrement pair.
// - Single-operand memory instructions qualify.
// - Word memory shifts by one qualify.
`timescale 1ns/10ps
`default_nettype none

module loop_mode_ctrl
  import loop_mode_pkg::*;
(
  input  wire logic        ref_clk_in,
  input  wire logic        reset_in,
  input  wire logic        opword_valid_in,
  input  wire logic [15:0] opword_in,
  input  wire logic        ext_valid_in,
  input  wire logic [15:0] ext_word_in,
  input  wire logic        instr_end_in,
  input  wire logic        branch_exec_in,
  input  wire logic [15:0] branch_disp_in,
  input  wire logic [15:0] count_low_in,
  input  wire logic        cond_true_in,
  input  wire logic        irq_pending_in,
  input  wire logic        trace_in,
  input  wire logic        bus_error_in,
  input  wire logic        exception_return_in,
  output logic             loop_active_out,
  output logic             fetch_inhibit_out,
  output logic [15:0]      decode_word_out,
  output logic [15:0]      queue_word0_out,
  output logic [15:0]      queue_word1_out,
  output logic [15:0]      count_result_out,
  output logic             count_write_out,
  output logic             branch_taken_out,
  output logic             irq_accept_out,
  output logic             trace_take_out,
  output logic             refill_out
);

  function automatic logic is_mem(input logic [2:0] mode);
    is_mem = (mode == MODE_IND) || (mode == MODE_POST) ||
             (mode == MODE_PRE);
  endfunction : is_mem

  function automatic logic is_counted(input logic [15:0] op);
    is_counted = (op[15:12] == GRP_COND) && (op[7:3] == COUNTED_FIELD);
  endfunction : is_counted

  // Decides whether a one-word opcode may be repeated without fetches.
  // Any encoding needing extension words falls outside the indirect modes.
  function automatic logic qualifies(input logic [15:0] op);
    logic [2:0] src;
    logic [2:0] dst;
    logic [2:0] opm;
    logic       q;
    src = op[5:3];
    dst = op[8:6];
    opm = op[8:6];
    q   = 1'b0;
    if (op[15:14] == 2'b00 && op[13:12] != 2'b00) begin
      unique case (src)
        MODE_IND:  q = is_mem(dst);
        MODE_POST: q = (dst == MODE_IND) || (dst == MODE_PRE);
        MODE_PRE:  q = is_mem(dst);
        MODE_DREG: q = (dst == MODE_IND) || (dst == MODE_POST);
        default:   q = 1'b0;
      endcase
    end else if (op[15:12] == GRP_ADD || op[15:12] == GRP_SUB ||
                 op[15:12] == GRP_AND || op[15:12] == GRP_OR ||
                 op[15:12] == GRP_CMP) begin
      if (!opm[2] && opm[1:0] != SIZE_NONE) begin
        q = is_mem(src);
      end else if (opm[1:0] == SIZE_NONE) begin
        q = is_mem(src) && (op[15:12] == GRP_ADD ||
            op[15:12] == GRP_SUB || op[15:12] == GRP_CMP);
      end else if (op[15:12] == GRP_CMP) begin
        q = is_mem(src) || (src == MODE_AREG);
      end else if (op[15:12] == GRP_ADD || op[15:12] == GRP_SUB) begin
        q = is_mem(src) || (src == MODE_AREG);
      end else begin
        q = is_mem(src) ||
            (op[8:3] == EXT_PAIR_FIELD && op[7:6] == 2'b00);
      end
    end else if (op[15:12] == GRP_MISC) begin
      if (op[15:6] == DEC_NEGATE_OP) begin
        q = is_mem(src);
      end else if (op[7:6] != SIZE_NONE &&
                   (op[11:8] == SUB_NEG_EXTEND || op[11:8] == SUB_CLEAR ||
                    op[11:8] == SUB_NEG || op[11:8] == SUB_NOT ||
                    op[11:8] == SUB_TEST)) begin
        q = is_mem(src);
      end
    end else if (op[15:11] == GRP_SHIFT_MEM && op[7:6] == SIZE_NONE) begin
      q = is_mem(src);
    end
    qualifies = q;
  endfunction : qualifies

  loop_state_t state;
  logic [15:0] prior_word;
  logic [15:0] latest_word;
  logic [15:0] next_count;
  logic        loops_back;
  logic        running;

  assign running    = (state == LOOP_RUNNING);
  assign next_count = count_low_in - COUNT_STEP;
  assign loops_back = (next_count != COUNT_DONE) && !cond_true_in;

  // Track the last two opcode words so the branch knows its target.
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      prior_word  <= 16'h0000;
      latest_word <= 16'h0000;
    end else if (opword_valid_in && !running) begin
      prior_word  <= latest_word;
      latest_word <= opword_in;
    end
  end

  // The loop itself; entry needs no software action at all.
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      state <= LOOP_IDLE;
    end else if (bus_error_in) begin
      state <= (state == LOOP_RUNNING || state == LOOP_FAULTED) ?
               LOOP_FAULTED : LOOP_IDLE;
    end else begin
      unique case (state)
        LOOP_IDLE: begin
          if (branch_exec_in && loops_back && !trace_in &&
              !irq_pending_in && branch_disp_in == LOOP_DISP &&
              is_counted(latest_word) && qualifies(prior_word)) begin
            state <= LOOP_ARMED;
          end
        end
        LOOP_ARMED: begin
          if (trace_in) begin
            state <= LOOP_IDLE;
          end else if (opword_valid_in) begin
            state <= (opword_in == prior_word && qualifies(opword_in)) ?
                     LOOP_FILLING : LOOP_IDLE;
          end
        end
        LOOP_FILLING: begin
          if (trace_in) begin
            state <= LOOP_IDLE;
          end else if (opword_valid_in) begin
            // The tracker has already shifted here, so latest_word holds the looped
            // word; the queued copy of the branch word, like prior_word, is the reference.
            state <= (opword_in == queue_word0_out) ?
                     LOOP_RUNNING : LOOP_IDLE;
          end
        end
        LOOP_RUNNING: begin
          if (branch_exec_in &&
              (!loops_back || irq_pending_in || trace_in)) begin
            state <= LOOP_IDLE;
          end
        end
        LOOP_FAULTED: begin
          if (exception_return_in) begin
            state <= LOOP_RUNNING;
          end
        end
      endcase
    end
  end

  // Words held for the loop; frozen while it runs or waits on a fault.
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      decode_word_out <= 16'h0000;
      queue_word0_out <= 16'h0000;
      queue_word1_out <= 16'h0000;
    end else if (state == LOOP_IDLE || state == LOOP_ARMED) begin
      if (opword_valid_in) begin
        decode_word_out <= opword_in;
        queue_word0_out <= opword_in;
      end
      if (ext_valid_in) begin
        queue_word1_out <= ext_word_in;
      end
      if (state == LOOP_IDLE && branch_exec_in) begin
        decode_word_out <= prior_word;
        queue_word0_out <= latest_word;
        queue_word1_out <= branch_disp_in;
      end
      if (state == LOOP_ARMED && opword_valid_in) begin
        queue_word0_out <= latest_word;
      end
    end else if (state == LOOP_FILLING && opword_valid_in) begin
      queue_word0_out <= opword_in;
    end
  end

  // Counted branch results handed back to the execution unit.
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      count_result_out <= 16'h0000;
      count_write_out  <= 1'b0;
      branch_taken_out <= 1'b0;
    end else begin
      count_write_out  <= branch_exec_in && (next_count == COUNT_DONE);
      branch_taken_out <= branch_exec_in && loops_back;
      if (branch_exec_in) begin
        count_result_out <= next_count;
      end
    end
  end

  // Exception hand-offs; inside the loop the looped instruction's end
  // is not an interrupt point, so it and the branch run as one block between samples.
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      irq_accept_out <= 1'b0;
      trace_take_out <= 1'b0;
      refill_out     <= 1'b0;
    end else begin
      irq_accept_out <= irq_pending_in && (branch_exec_in ||
                        (instr_end_in && !running));
      trace_take_out <= trace_in &&
                        (branch_exec_in || instr_end_in);
      refill_out     <= running && branch_exec_in &&
                        !loops_back;
    end
  end

  assign loop_active_out   = (state == LOOP_FILLING) || running ||
                             (state == LOOP_FAULTED);
  assign fetch_inhibit_out = running;

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);
  // Only the reset check looks through reset; all others wait it out.

  AST_QUEUE_HELD: assert property (
    fetch_inhibit_out && $past(fetch_inhibit_out) |->
      $stable(decode_word_out) && $stable(queue_word0_out) &&
      $stable(queue_word1_out))
    else $error("Loop words changed while the loop ran.");

  AST_INHIBIT_ONLY_LOOP: assert property (
    fetch_inhibit_out |-> loop_active_out && !refill_out)
    else $error("Fetches stopped outside the loop.");

  AST_ENTRY_MINUS_FOUR: assert property (
    state == LOOP_IDLE && branch_exec_in &&
    branch_disp_in != LOOP_DISP |=> state == LOOP_IDLE)
    else $error("Loop armed with a wrong displacement.");

  AST_COMMIT_SECOND_FETCH: assert property (
    state == LOOP_ARMED && !trace_in && !bus_error_in && opword_valid_in &&
    opword_in == decode_word_out && qualifies(opword_in) |=>
      loop_active_out && !fetch_inhibit_out)
    else $error("No commit on the second looped fetch.");

  AST_COUNT_DECREMENT: assert property (
    branch_exec_in |=> count_result_out == $past(count_low_in) - 16'h0001
      && count_write_out == (count_result_out == COUNT_DONE))
    else $error("Counter result is wrong.");

  AST_NO_IRQ_MID_LOOP: assert property (
    fetch_inhibit_out && instr_end_in && !branch_exec_in |=>
      !irq_accept_out)
    else $error("Interrupt taken after the looped instruction.");

  AST_IRQ_EXITS: assert property (
    fetch_inhibit_out && branch_exec_in && irq_pending_in &&
    !bus_error_in |=> irq_accept_out && !loop_active_out)
    else $error("Interrupt did not end the loop.");

  AST_TRACE_BLOCKS: assert property (
    trace_in && state != LOOP_RUNNING && state != LOOP_FAULTED |=>
      !loop_active_out)
    else $error("Loop entered while tracing.");

  AST_RESET_CLEARS: assert property (
    disable iff (1'b0)
    reset_in |=> !loop_active_out && !fetch_inhibit_out && !refill_out)
    else $error("Reset left loop state behind.");

  AST_FAULT_RESUME: assert property (
    state == LOOP_FAULTED && exception_return_in && !bus_error_in |=>
      fetch_inhibit_out && $stable(decode_word_out))
    else $error("Loop refetched after a bus error return.");

  AST_EXIT_REFILL: assert property (
    fetch_inhibit_out && branch_exec_in && !bus_error_in &&
    next_count == COUNT_DONE |=> refill_out && !fetch_inhibit_out)
    else $error("Normal exit did not refill.");

  AST_TRACE_TAKES: assert property (
    trace_in && (branch_exec_in || instr_end_in) |=>
      trace_take_out)
    else $error("Trace exception missed after an instruction.");

  AST_ARM_NEEDS_QUAL: assert property (
    state == LOOP_IDLE && branch_exec_in && !qualifies(prior_word) |=>
      state == LOOP_IDLE)
    else $error("Loop armed on an instruction that does not qualify.");

  AST_LOOP_HOLDS: assert property (
    fetch_inhibit_out && branch_exec_in && loops_back && !irq_pending_in &&
    !trace_in && !bus_error_in |=> fetch_inhibit_out)
    else $error("Loop left while the branch still looped back.");

  AST_FILL_COMMIT: assert property (
    state == LOOP_FILLING && !trace_in && !bus_error_in &&
    opword_valid_in && opword_in == queue_word0_out |=> fetch_inhibit_out)
    else $error("Loop did not start on the second branch fetch.");

  AST_COUNT_WRITE: assert property (
    branch_exec_in && count_low_in == 16'h0000 |=>
      count_write_out && !branch_taken_out)
    else $error("Exhausted count did not fall through.");

  COV_ENTER_LOOP: cover property (
    state == LOOP_ARMED ##[1:20] state == LOOP_RUNNING);
  COV_COUNT_EXIT: cover property (fetch_inhibit_out ##1 refill_out);
  COV_IRQ_EXIT: cover property (fetch_inhibit_out ##1 irq_accept_out);
  COV_FAULT_RESUME: cover property (
    state == LOOP_FAULTED ##[1:20] fetch_inhibit_out);
  COV_IRQ_REENTRY: cover property (
    irq_accept_out ##[1:40] fetch_inhibit_out);

endmodule : loop_mode_ctrl

`default_nettype wire

/* File: rtl/loop_mode_pkg.sv */
// Constants and types shared by the single-instruction loop-mode control.
package loop_mode_pkg;

  // Branch displacement that closes a loop over one one-word instruction.
  localparam logic [15:0] LOOP_DISP       = 16'hFFFC;
  // Counter value at which the counted branch is exhausted.
  localparam logic [15:0] COUNT_DONE      = 16'hFFFF;
  localparam logic [15:0] COUNT_STEP      = 16'h0001;

  // Effective address mode field codes.
  localparam logic [2:0]  MODE_DREG       = 3'h0;
  localparam logic [2:0]  MODE_AREG       = 3'h1;
  localparam logic [2:0]  MODE_IND        = 3'h2;
  localparam logic [2:0]  MODE_POST       = 3'h3;
  localparam logic [2:0]  MODE_PRE        = 3'h4;
  localparam logic [1:0]  SIZE_NONE       = 2'h3;

  // Opcode group codes held in the top four bits, the top five for the memory shift group.
  localparam logic [3:0]  GRP_MISC        = 4'h4;
  localparam logic [3:0]  GRP_COND        = 4'h5;
  localparam logic [3:0]  GRP_OR          = 4'h8;
  localparam logic [3:0]  GRP_SUB         = 4'h9;
  localparam logic [3:0]  GRP_CMP         = 4'hB;
  localparam logic [3:0]  GRP_AND         = 4'hC;
  localparam logic [3:0]  GRP_ADD         = 4'hD;
  localparam logic [4:0]  GRP_SHIFT_MEM   = 5'h1C;

  // Sub-fields of the single operand group, the extend pair and the counted branch.
  localparam logic [3:0]  SUB_NEG_EXTEND  = 4'h0;
  localparam logic [3:0]  SUB_CLEAR       = 4'h2;
  localparam logic [3:0]  SUB_NEG         = 4'h4;
  localparam logic [3:0]  SUB_NOT         = 4'h6;
  localparam logic [3:0]  SUB_TEST        = 4'hA;
  localparam logic [9:0]  DEC_NEGATE_OP   = 10'h120;
  localparam logic [5:0]  EXT_PAIR_FIELD  = 6'h21;
  localparam logic [4:0]  COUNTED_FIELD   = 5'h19;

  typedef enum logic [2:0] {
    LOOP_IDLE,
    LOOP_ARMED,
    LOOP_FILLING,
    LOOP_RUNNING,
    LOOP_FAULTED
  } loop_state_t;

endpackage : loop_mode_pkg

/* File: tb/loop_fetch_model.sv */
// Instruction fetch source that feeds opcode and extension words.
`timescale 1ns/10ps
`default_nettype none

module loop_fetch_model (
  input  wire logic        ref_clk_in,
  input  wire logic        fetch_inhibit_in,
  output logic             opword_valid_out,
  output logic [15:0]      opword_out,
  output logic             ext_valid_out,
  output logic [15:0]      ext_word_out
);

  initial begin
    opword_valid_out = 1'b0;
    opword_out       = 16'h0000;
    ext_valid_out    = 1'b0;
    ext_word_out     = 16'h0000;
  end

  // A word is offered for one cycle; afterwards the line shows its inverse,
  // so a design that samples late sees a wrong word rather than a lucky one.
  task automatic fetch(input logic ext, input logic [15:0] w);
    @(negedge ref_clk_in);
    if (fetch_inhibit_in) begin
      return;
    end
    if (ext) begin
      ext_valid_out = 1'b1;
      ext_word_out  = w;
    end else begin
      opword_valid_out = 1'b1;
      opword_out       = w;
    end
    @(negedge ref_clk_in);
    opword_valid_out = 1'b0;
    ext_valid_out    = 1'b0;
    if (ext) begin
      ext_word_out = ~w;
    end else begin
      opword_out = ~w;
    end
  endtask : fetch

endmodule : loop_fetch_model
`default_nettype wire

/* File: tb/single_instruction_loop_mode_test.sv */
// Self-checking bench for the single-instruction loop-mode control.
`timescale 1ns/10ps
`default_nettype none

module single_instruction_loop_mode_test;
  import loop_mode_pkg::*;

  localparam logic [15:0] BRANCH_OP = 16'h57C8;
  localparam logic [15:0] MOVE_OP   = 16'h3298;

  logic        ref_clk, reset, op_v, ext_v, iend, bex, cond, irq, trace;
  logic        berr, eret, active, inhibit, cwr, taken, iacc, ttake, refill;
  logic [15:0] op_w, ext_w, disp, cnt, dec_w, q0, q1, cres;
  int          err_count;
  int          samples_checked;

  loop_mode_ctrl uut (.ref_clk_in(ref_clk), .reset_in(reset),
    .opword_valid_in(op_v), .opword_in(op_w), .ext_valid_in(ext_v),
    .ext_word_in(ext_w), .instr_end_in(iend), .branch_exec_in(bex),
    .branch_disp_in(disp), .count_low_in(cnt), .cond_true_in(cond),
    .irq_pending_in(irq), .trace_in(trace), .bus_error_in(berr),
    .exception_return_in(eret), .loop_active_out(active),
    .fetch_inhibit_out(inhibit), .decode_word_out(dec_w),
    .queue_word0_out(q0), .queue_word1_out(q1), .count_result_out(cres),
    .count_write_out(cwr), .branch_taken_out(taken),
    .irq_accept_out(iacc), .trace_take_out(ttake), .refill_out(refill));

  loop_fetch_model fm (.ref_clk_in(ref_clk), .fetch_inhibit_in(inhibit),
    .opword_valid_out(op_v), .opword_out(op_w), .ext_valid_out(ext_v),
    .ext_word_out(ext_w));

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  task automatic chk(input string n, input logic [15:0] s, e);
    samples_checked++;
    if (s !== e) begin
      $display("mismatch %s expected %h seen %h", n, e, s);
      err_count++;
    end
  endtask : chk

  task automatic end_sim;
    $display("checked %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_sim

  // Counted branch: held one cycle, outputs are read at the next fall.
  task automatic br(input logic [15:0] d, c, input logic t);
    @(negedge ref_clk);
    bex  = 1'b1;
    disp = d;
    cnt  = c;
    cond = t;
    @(negedge ref_clk);
    bex  = 1'b0;
    disp = ~d;
    cnt  = ~c;
  endtask : br

  // Single-cycle event: 0 end, 1 bus error, 2 return, 3 reset.
  task automatic ev(input int k);
    @(negedge ref_clk);
    {iend, berr, eret, reset} = 4'h8 >> k;
    @(negedge ref_clk);
    {iend, berr, eret, reset} = 4'h0;
  endtask : ev

  task automatic enter(input logic [15:0] l, d, input logic q);
    fm.fetch(1'b0, l);
    fm.fetch(1'b0, BRANCH_OP);
    fm.fetch(1'b1, d);
    br(d, 16'h0005, 1'b0);
    chk("taken", taken, 16'h0001);
    chk("count", cres, 16'h0004);
    if (q) begin
      chk("decode", dec_w, l);
      chk("queue0", q0, BRANCH_OP);
      chk("queue1", q1, d);
    end
    fm.fetch(1'b0, l);
    chk("active", active, q);
    fm.fetch(1'b0, BRANCH_OP);
    chk("inhibit", inhibit, q);
  endtask : enter

  task automatic run_and_exit;
    enter(MOVE_OP, LOOP_DISP, 1'b1);
    br(LOOP_DISP, 16'h0001, 1'b0);
    chk("inhibit", inhibit, 16'h0001);
    chk("count", cres, 16'h0000);
    br(LOOP_DISP, 16'h0000, 1'b0);
    chk("write", cwr, 16'h0001);
    chk("refill", refill, 16'h0001);
    chk("inhibit", inhibit, 16'h0000);
    enter(MOVE_OP, LOOP_DISP, 1'b1);
    br(LOOP_DISP, 16'h0007, 1'b1);
    chk("write", cwr, 16'h0000);
    chk("refill", refill, 16'h0001);
  endtask : run_and_exit

  task automatic refused;
    enter(MOVE_OP, 16'hFFF8, 1'b0);
    trace = 1'b1;
    br(16'hFFF8, 16'h0003, 1'b0);
    chk("trace", ttake, 16'h0001);
    ev(0);
    chk("trace", ttake, 16'h0001);
    enter(MOVE_OP, LOOP_DISP, 1'b0);
    trace = 1'b0;
  endtask : refused

  task automatic interrupt;
    enter(MOVE_OP, LOOP_DISP, 1'b1);
    irq = 1'b1;
    ev(0);
    chk("irq", iacc, 16'h0000);
    chk("inhibit", inhibit, 16'h0001);
    br(LOOP_DISP, 16'h0005, 1'b0);
    irq = 1'b0;
    chk("irq", iacc, 16'h0001);
    chk("active", active, 16'h0000);
    enter(MOVE_OP, LOOP_DISP, 1'b1);
  endtask : interrupt

  task automatic fault_and_reset;
    ev(1);
    chk("active", active, 16'h0001);
    chk("inhibit", inhibit, 16'h0000);
    ev(2);
    chk("inhibit", inhibit, 16'h0001);
    ev(3);
    chk("active", active, 16'h0000);
    chk("inhibit", inhibit, 16'h0000);
  endtask : fault_and_reset

  // One opcode through entry, then a clean exit so the next starts idle.
  task automatic try_op(input logic [15:0] op, input logic ok);
    enter(op, LOOP_DISP, ok);
    br(LOOP_DISP, 16'h0000, 1'b1);
  endtask : try_op

  // Each qualifying class once, then encodings that must be turned away.
  task automatic qualify;
    try_op(16'h3298, 1'b1);
    try_op(16'hD250, 1'b1);
    try_op(16'hD0D0, 1'b1);
    try_op(16'hB150, 1'b1);
    try_op(16'hB348, 1'b1);
    try_op(16'hD348, 1'b1);
    try_op(16'hC308, 1'b1);
    try_op(16'h4250, 1'b1);
    try_op(16'h4810, 1'b1);
    try_op(16'hE1D0, 1'b1);
    try_op(16'h3218, 1'b0);
    try_op(16'hC348, 1'b0);
    try_op(16'h4268, 1'b0);
  endtask : qualify

  initial begin
    {iend, bex, cond, irq, trace, berr, eret} = 7'h00;
    disp            = 16'h0000;
    cnt             = 16'h0000;
    err_count       = 0;
    samples_checked = 0;
    reset           = 1'b1;
    repeat (5) @(negedge ref_clk);
    reset = 1'b0;
    chk("active", active, 16'h0000);
    run_and_exit();
    refused();
    interrupt();
    fault_and_reset();
    qualify();
    end_sim();
  end

  // Guards against a hang; the full run needs far fewer cycles.
  initial begin
    repeat (5000) @(posedge ref_clk);
    err_count++;
    end_sim();
  end

endmodule : single_instruction_loop_mode_test
`default_nettype wire
